// ==== bpps_pkg.sv ====
package bpps_pkg;

    // serial frame positions, counted in received bits
    localparam logic [6:0] CMD_END = 7'h10;
    localparam logic [6:0] CMD_PEC_END = 7'h20;
    localparam logic [6:0] DATA_END = 7'h50;
    localparam logic [6:0] DATA_PEC_END = 7'h60;
    localparam logic [6:0] BIT_CNT_MAX = 7'h7F;

    // command codes
    localparam logic [15:0] START_PIN_PULSING_CMD = 16'h0019;
    localparam logic [15:0] WRITE_PIN_PULSE_SETTINGS_CMD = 16'h0014;
    localparam logic [15:0] CLEAR_PIN_PULSE_SETTINGS_CMD = 16'h0018;
    localparam logic [15:0] POLL_COMPLETION_CMD = 16'h0714;

    // packet check code
    localparam logic [14:0] PEC_SEED = 15'h0010;

    // pin count and setting layout
    localparam int PIN_COUNT = 12;
    localparam int SETTING_BITS = 48;
    localparam logic [47:0] SETTINGS_RESET = 48'h0000_0000_0000;

    // action codes held in the nibble map
    localparam logic [3:0] ACT_RELEASE = 4'h0;
    localparam logic [3:0] ACT_HIGH = 4'h8;
    localparam logic [3:0] ACT_LOW = 4'h9;
    localparam logic [63:0] NIBBLE_MAP_DEFAULT = 64'h9999_9998_7654_3210;

    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int PULSE_PERIOD_NS = 155000;
    localparam int PULSE_WIDTH_NS = 77600;
    localparam logic [11:0] PERIOD_CYCLES =
        12'(PULSE_PERIOD_NS / CLK_PERIOD_NS);
    localparam logic [11:0] WIDTH_CYCLES =
        12'((PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // one bit of the 15-bit check code
    function automatic logic [14:0] pec_step(input logic [14:0] c,
                                             input logic d);
        logic in0;
        in0 = d ^ c[14];
        pec_step = {c[13] ^ in0, c[12:10], c[9] ^ in0, c[8], c[7] ^ in0,
                    c[6] ^ in0, c[5:4], c[3] ^ in0, c[2] ^ in0, c[1:0],
                    in0};
    endfunction : pec_step

endpackage : bpps_pkg

// ==== bpps_pin_drive.sv ====
`timescale 1ns/1ns
module bpps_pin_drive (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // pin behaviour
    input wire logic [3:0] action,
    input wire logic engaged,
    input wire logic running,
    input wire logic phase_hi,
    input wire logic [2:0] period_idx,
    input wire logic discharge,
    // pin
    output logic level,
    output logic drive_en
);

    // per-pin drive decision
    always_ff @(posedge core_clk) begin
        if (rst) begin
            level <= 1'b0;
            drive_en <= 1'b0;
        end else if (discharge) begin
            level <= 1'b0;
            drive_en <= 1'b1;
        end else if (!engaged) begin
            level <= 1'b0;
            drive_en <= 1'b0;
        end else begin
            case (action)
                bpps_pkg::ACT_HIGH: begin
                    level <= 1'b1;
                    drive_en <= 1'b1;
                end
                bpps_pkg::ACT_LOW: begin
                    level <= 1'b0;
                    drive_en <= 1'b1;
                end
                4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
                    // pulse k high while index below the count
                    level <= running && phase_hi &&
                        ({1'b0, period_idx} < action);
                    drive_en <= 1'b1;
                end
                default: begin
                    level <= 1'b0;
                    drive_en <= 1'b0;
                end
            endcase
        end
    end

endmodule : bpps_pin_drive

// ==== bpps_sequencer.sv ====
`timescale 1ns/1ns
module bpps_sequencer #(
    parameter logic [63:0] NIBBLE_MAP = bpps_pkg::NIBBLE_MAP_DEFAULT
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // serial port
    input wire logic csb,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    // discharge bits from configuration
    input wire logic [11:0] cell_discharge_bit,
    // balance pins
    output logic [11:0] pin_level,
    output logic [11:0] pin_drive_en
);

    logic [2:0] csb_s;
    logic [2:0] sck_s;
    logic [1:0] sdi_s;
    logic [6:0] bit_cnt;
    logic [15:0] shreg;
    logic [15:0] cmd;
    logic [47:0] data;
    logic [14:0] crc;
    logic [14:0] cmd_crc;
    logic [14:0] data_crc;
    logic cmd_ok;
    logic data_ok;
    logic cmd_fire;
    logic polling;
    logic [47:0] settings;
    logic running;
    logic engaged;
    logic [11:0] per_cnt;
    logic [2:0] per_idx;
    logic [2:0] max_cnt;
    logic sck_rise;
    logic csb_rise;
    logic csb_low;
    logic [6:0] next_bit_cnt;
    logic [15:0] next_shreg;
    logic [14:0] next_crc;
    logic wr_commit;
    logic clear_fire;
    logic start_fire;
    logic [2:0] start_max;

    // map entry of one nibble
    function automatic logic [3:0] action_of(input logic [3:0] nib);
        action_of = NIBBLE_MAP[{nib, 2'b00} +: 4];
    endfunction : action_of

    // pulse count of one action, zero for non-pulse actions
    function automatic logic [2:0] count_of(input logic [3:0] act);
        count_of = act[3] ? 3'h0 : act[2:0];
    endfunction : count_of

    // two-stage synchronisers for the serial pins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            csb_s <= 3'h7;
            sck_s <= 3'h7;
            sdi_s <= 2'h0;
        end else begin
            csb_s <= {csb_s[1:0], csb};
            sck_s <= {sck_s[1:0], sck};
            sdi_s <= {sdi_s[0], sdi};
        end
    end

    // edges and next values of the receiver
    assign sck_rise = sck_s[1] && !sck_s[2];
    assign csb_rise = csb_s[1] && !csb_s[2];
    assign csb_low = !csb_s[1];
    assign next_bit_cnt = (bit_cnt == bpps_pkg::BIT_CNT_MAX) ?
        bit_cnt : bit_cnt + 7'h01;
    assign next_shreg = {shreg[14:0], sdi_s[1]};
    assign next_crc = bpps_pkg::pec_step(crc, sdi_s[1]);

    // bit receiver, sampled on rising clock edges
    always_ff @(posedge core_clk) begin
        if (rst || !csb_low) begin
            bit_cnt <= 7'h00;
            shreg <= 16'h0000;
            crc <= bpps_pkg::PEC_SEED;
            cmd_fire <= 1'b0;
            if (rst) begin
                cmd <= 16'h0000;
                data <= 48'h0000_0000_0000;
                cmd_crc <= 15'h0000;
                data_crc <= 15'h0000;
                cmd_ok <= 1'b0;
                data_ok <= 1'b0;
            end
        end else if (sck_rise) begin
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            crc <= next_crc;
            cmd_fire <= 1'b0;
            if (next_bit_cnt == bpps_pkg::CMD_END) begin
                cmd <= next_shreg;
                cmd_crc <= next_crc;
                cmd_ok <= 1'b0;
                data_ok <= 1'b0;
            end
            if (next_bit_cnt == bpps_pkg::CMD_PEC_END) begin
                // check code ends in a zero pad bit
                cmd_ok <= next_shreg == {cmd_crc, 1'b0};
                cmd_fire <= next_shreg == {cmd_crc, 1'b0};
                crc <= bpps_pkg::PEC_SEED;
            end
            if (next_bit_cnt > bpps_pkg::CMD_PEC_END &&
                next_bit_cnt <= bpps_pkg::DATA_END) begin
                data <= {data[46:0], sdi_s[1]};
            end
            if (next_bit_cnt == bpps_pkg::DATA_END) begin
                data_crc <= next_crc;
            end
            if (next_bit_cnt == bpps_pkg::DATA_PEC_END) begin
                data_ok <= next_shreg == {data_crc, 1'b0};
            end
        end else begin
            cmd_fire <= 1'b0;
        end
    end

    // decoded command events
    assign wr_commit = csb_rise && cmd_ok &&
        bit_cnt == bpps_pkg::DATA_PEC_END &&
        cmd == bpps_pkg::WRITE_PIN_PULSE_SETTINGS_CMD;
    assign clear_fire = cmd_fire &&
        cmd == bpps_pkg::CLEAR_PIN_PULSE_SETTINGS_CMD;
    assign start_fire = cmd_fire && !running &&
        cmd == bpps_pkg::START_PIN_PULSING_CMD;

    // longest train among all pins
    always_comb begin
        start_max = 3'h0;
        for (int i = 0; i < bpps_pkg::PIN_COUNT; i++) begin
            if (count_of(action_of(settings[4*i +: 4])) > start_max) begin
                start_max = count_of(action_of(settings[4*i +: 4]));
            end
        end
    end

    // setting storage
    always_ff @(posedge core_clk) begin
        if (rst) begin
            settings <= bpps_pkg::SETTINGS_RESET;
        end else if (clear_fire) begin
            settings <= bpps_pkg::SETTINGS_RESET;
        end else if (wr_commit && !running) begin
            settings <= data_ok ? data : bpps_pkg::SETTINGS_RESET;
        end
    end

    // pulse timebase and train sequencing
    always_ff @(posedge core_clk) begin
        if (rst) begin
            running <= 1'b0;
            engaged <= 1'b0;
            per_cnt <= 12'h000;
            per_idx <= 3'h0;
            max_cnt <= 3'h0;
        end else if (clear_fire) begin
            running <= 1'b0;
            engaged <= 1'b0;
            per_cnt <= 12'h000;
            per_idx <= 3'h0;
        end else if (start_fire) begin
            running <= start_max != 3'h0;
            engaged <= 1'b1;
            per_cnt <= 12'h000;
            per_idx <= 3'h0;
            max_cnt <= start_max;
        end else if (running) begin
            if (per_cnt == bpps_pkg::PERIOD_CYCLES - 12'h001) begin
                per_cnt <= 12'h000;
                per_idx <= per_idx + 3'h1;
                if (per_idx + 3'h1 == max_cnt) begin
                    running <= 1'b0;
                end
            end else begin
                per_cnt <= per_cnt + 12'h001;
            end
        end
    end

    // polling: data out held low while pulsing
    always_ff @(posedge core_clk) begin
        if (rst || !csb_low) begin
            polling <= 1'b0;
        end else if (cmd_fire &&
            (cmd == bpps_pkg::START_PIN_PULSING_CMD ||
             cmd == bpps_pkg::POLL_COMPLETION_CMD)) begin
            polling <= 1'b1;
        end
    end

    // open-drain data out
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sdo_oe <= 1'b0;
            sdo_out <= 1'b0;
        end else begin
            sdo_oe <= polling && running && csb_low;
            sdo_out <= 1'b0;
        end
    end

    // one drive stage per balance pin
    for (genvar g = 0; g < bpps_pkg::PIN_COUNT; g++) begin : g_pin
        bpps_pin_drive bpps_pin_drive_inst (
            .core_clk(core_clk),
            .rst(rst),
            .action(action_of(settings[4*g +: 4])),
            .engaged(engaged),
            .running(running),
            .phase_hi(per_cnt < bpps_pkg::WIDTH_CYCLES),
            .period_idx(per_idx),
            .discharge(cell_discharge_bit[g]),
            .level(pin_level[g]),
            .drive_en(pin_drive_en[g])
        );
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    a_start_runs: assert property (
        start_fire && start_max != 3'h0 && !clear_fire
        |=> running && per_cnt == 12'h000)
        else $error("start did not begin train");
    a_busy_no_restart: assert property (
        running && cmd_fire && !clear_fire &&
        per_cnt != bpps_pkg::PERIOD_CYCLES - 12'h001
        |=> per_cnt == $past(per_cnt) + 12'h001)
        else $error("start restarted a running train");
    a_busy_no_write: assert property (
        running && wr_commit && !clear_fire |=> $stable(settings))
        else $error("write accepted while pulsing");
    a_bad_data_clear: assert property (
        wr_commit && !running && !data_ok && !clear_fire
        |=> settings == 48'h0000_0000_0000)
        else $error("bad data check did not clear");
    a_clear_release: assert property (
        clear_fire |=> !running && !engaged &&
        settings == 48'h0000_0000_0000 ##1
        pin_drive_en == $past(cell_discharge_bit))
        else $error("clear did not release pins");
    a_store_on_rise: assert property (
        !wr_commit && !clear_fire |=> $stable(settings))
        else $error("settings changed outside write end");
    a_period_wrap: assert property (
        running && !clear_fire && !start_fire &&
        per_cnt == bpps_pkg::PERIOD_CYCLES - 12'h001
        |=> per_cnt == 12'h000 && per_idx == $past(per_idx) + 3'h1)
        else $error("pulse period wrong");
    a_poll_low: assert property (
        polling && running && csb_low |=> sdo_oe && !sdo_out)
        else $error("data out not low while pulsing");
    a_done_release_sdo: assert property (
        !running |=> !sdo_oe)
        else $error("data out held low after completion");
    a_discharge_low: assert property (
        cell_discharge_bit != 12'h000 |=>
        (pin_drive_en & $past(cell_discharge_bit)) ==
        $past(cell_discharge_bit) &&
        (pin_level & $past(cell_discharge_bit)) == 12'h000)
        else $error("discharge did not force pin low");

endmodule : bpps_sequencer

// ==== bpps_pulse_reader.sv ====
`timescale 1ns/1ns
module bpps_pulse_reader (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // pins 0 and 1 as the converter sees them
    input wire logic [1:0] pin_level,
    input wire logic [1:0] pin_drive_en,
    // pulse counts, pin 1 width and period in cycles
    output logic [3:0] cnt0,
    output logic [3:0] cnt1,
    output logic [15:0] hi_len,
    output logic [15:0] per_len
);
    logic [1:0] hi;
    logic [1:0] seen;
    logic [15:0] run;

    // an undriven pin reads low at the converter
    assign hi = pin_level & pin_drive_en;

    // converter counts each rising pulse as one mode step
    always_ff @(posedge core_clk) begin
        seen <= rst ? 2'h0 : hi;
        if (rst) begin
            cnt0 <= 4'h0;
            cnt1 <= 4'h0;
        end else begin
            if (hi[0] && !seen[0]) cnt0 <= cnt0 + 4'h1;
            if (hi[1] && !seen[1]) cnt1 <= cnt1 + 4'h1;
        end
    end

    // one run counter, restarted at each rise of pin 1
    always_ff @(posedge core_clk) begin
        run <= (rst || (hi[1] && !seen[1])) ? 16'h0001 : run + 16'h0001;
        if (!hi[1] && seen[1]) hi_len <= run;
        if (hi[1] && !seen[1]) per_len <= run;
    end
endmodule : bpps_pulse_reader

// ==== bpps_sequencer_bench.sv ====
`timescale 1ns/1ns
module bpps_sequencer_bench;
    logic core_clk, rst, csb, sck, sdi, sdo_out, sdo_oe;
    logic [11:0] cell_discharge_bit, pin_level, pin_drive_en;
    logic [3:0] cnt0, cnt1;
    logic [15:0] hi_len, per_len;
    int tests_run = 0;
    int miscompares = 0;

    bpps_sequencer bpps_sequencer_inst (.core_clk(core_clk), .rst(rst),
        .csb(csb), .sck(sck), .sdi(sdi), .sdo_out(sdo_out),
        .sdo_oe(sdo_oe), .cell_discharge_bit(cell_discharge_bit),
        .pin_level(pin_level), .pin_drive_en(pin_drive_en));

    bpps_pulse_reader bpps_pulse_reader_inst (.core_clk(core_clk),
        .rst(rst), .pin_level(pin_level[1:0]),
        .pin_drive_en(pin_drive_en[1:0]), .cnt0(cnt0), .cnt1(cnt1),
        .hi_len(hi_len), .per_len(per_len));

    // 20 MHz core clock
    always #25 core_clk = ~core_clk;

    // check code over the low n bits, first bit sent first
    function automatic logic [14:0] crc(input logic [47:0] v, input int n);
        logic [14:0] c;
        logic in0;
        c = bpps_pkg::PEC_SEED;
        for (int i = n - 1; i >= 0; i--) begin
            in0 = v[i] ^ c[14];
            c = {c[13:0], 1'b0} ^ (in0 ? 15'h4599 : 15'h0000);
        end
        return c;
    endfunction : crc

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one frame; ok flags choose good or broken check codes
    task automatic frame(input logic [15:0] cmd, input logic cok,
        input logic dat, input logic [47:0] d, input logic dok,
        input logic exp_sdo);
        logic [95:0] b;
        b = {cmd, crc({32'h0, cmd}, 16) ^ {14'h0, ~cok}, 1'b0, d,
             crc(d, 48) ^ {14'h0, ~dok}, 1'b0};
        csb = 1'b0;
        repeat (5) @(negedge core_clk);
        for (int i = 95; i >= (dat ? 0 : 64); i--) begin
            sck = 1'b0;
            sdi = b[i];
            repeat (10) @(negedge core_clk);
            sck = 1'b1;
            repeat (10) @(negedge core_clk);
        end
        repeat (20) @(negedge core_clk);
        chk({63'h0, sdo_oe}, {63'h0, exp_sdo});
        chk({63'h0, sdo_out}, 64'h0);
        csb = 1'b1;
        sdi = ~sdi;
        repeat (10) @(negedge core_clk);
    endtask : frame

    // mixed pins: 1 pulse, 7 pulses, high, low
    task automatic t_train;
        frame(bpps_pkg::WRITE_PIN_PULSE_SETTINGS_CMD, 1, 1,
              48'h0000_0000_9871, 1, 0);
        frame(bpps_pkg::START_PIN_PULSING_CMD, 0, 0, 48'h0, 1, 0);
        chk({52'h0, pin_drive_en}, 64'h0);
        frame(bpps_pkg::START_PIN_PULSING_CMD, 1, 0, 48'h0, 1, 1);
        frame(bpps_pkg::WRITE_PIN_PULSE_SETTINGS_CMD, 1, 1,
              48'h8888_8888_8888, 1, 0);
        frame(bpps_pkg::START_PIN_PULSING_CMD, 1, 0, 48'h0, 1, 1);
        frame(bpps_pkg::POLL_COMPLETION_CMD, 1, 0, 48'h0, 1, 1);
        for (int k = 0; k < 30000 && cnt1 !== 4'h7; k++)
            @(negedge core_clk);
        repeat (3200) @(negedge core_clk);
        frame(bpps_pkg::POLL_COMPLETION_CMD, 1, 0, 48'h0, 1, 0);
        chk({60'h0, cnt0}, 64'h1);
        chk({60'h0, cnt1}, 64'h7);
        chk({48'h0, hi_len}, {52'h0, bpps_pkg::WIDTH_CYCLES});
        chk({48'h0, per_len}, {52'h0, bpps_pkg::PERIOD_CYCLES});
        chk({52'h0, pin_drive_en}, 64'h00F);
        chk({52'h0, pin_level}, 64'h004);
        $display("train test done");
    endtask : t_train

    // clear in mid-train, then a discharge bit
    task automatic t_clear;
        frame(bpps_pkg::WRITE_PIN_PULSE_SETTINGS_CMD, 1, 1,
              48'h0000_0000_0070, 1, 0);
        frame(bpps_pkg::START_PIN_PULSING_CMD, 1, 0, 48'h0, 1, 1);
        for (int k = 0; k < 9000 && cnt1 !== 4'h9; k++)
            @(negedge core_clk);
        frame(bpps_pkg::CLEAR_PIN_PULSE_SETTINGS_CMD, 1, 0, 48'h0, 1,
              0);
        chk({52'h0, pin_drive_en}, 64'h0);
        frame(bpps_pkg::POLL_COMPLETION_CMD, 1, 0, 48'h0, 1, 0);
        repeat (3200) @(negedge core_clk);
        chk({60'h0, cnt1}, 64'h9);
        cell_discharge_bit = 12'h020;
        repeat (4) @(negedge core_clk);
        chk({62'h0, pin_drive_en[5], pin_level[5]}, 64'h2);
        cell_discharge_bit = 12'h000;
        repeat (4) @(negedge core_clk);
        $display("clear test done");
    endtask : t_clear

    // broken data check code wipes the settings
    task automatic t_bad_data;
        frame(bpps_pkg::WRITE_PIN_PULSE_SETTINGS_CMD, 1, 1,
              48'h0000_0000_0008, 1, 0);
        frame(bpps_pkg::WRITE_PIN_PULSE_SETTINGS_CMD, 1, 1,
              48'h0000_0000_0008, 0, 0);
        frame(bpps_pkg::START_PIN_PULSING_CMD, 1, 0, 48'h0, 1, 0);
        repeat (100) @(negedge core_clk);
        chk({52'h0, pin_drive_en}, 64'h0);
        $display("bad data test done");
    endtask : t_bad_data

    task automatic results;
        $display("checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    // tests need about 41000 cycles; allow twice that
    initial begin
        repeat (85000) @(posedge core_clk);
        miscompares++;
        results();
    end

    // reset, then the scenarios in turn
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        csb = 1'b1;
        sck = 1'b1;
        sdi = 1'b0;
        cell_discharge_bit = 12'h000;
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        repeat (5) @(negedge core_clk);
        t_train();
        t_clear();
        t_bad_data();
        results();
    end
endmodule : bpps_sequencer_bench
